// ===== core/acim_defs.svh
/*
 constants of the analog channel image mapper: sizes, register offsets,
 config field positions, reset values and timing counts.
 assumes it is included by bare name from the package and the modules.
*/
`ifndef ACIM_DEFS_SVH
`define ACIM_DEFS_SVH

`define ACIM_CH_MAX 4
`define ACIM_IMG_BYTES 16
`define ACIM_PTR_W 5
`define ACIM_STRAP_W 16

// apb byte addresses
`define ACIM_ADDR_CTRL 12'h000
`define ACIM_ADDR_CFG 12'h004
`define ACIM_ADDR_LAYOUT 12'h008
`define ACIM_ADDR_SERIAL_CB 12'h00c
`define ACIM_ADDR_ACTIVE_CB 12'h010

// config word fields
`define ACIM_CFG_TYPE_LSB 0
`define ACIM_CFG_TYPE_MSB 1
`define ACIM_CFG_BE_BIT 2
`define ACIM_CFG_ALIGN_BIT 3
`define ACIM_CFG_CS_LSB 4
`define ACIM_CFG_CS_MSB 7
`define ACIM_CFG_CNT_LSB 8
`define ACIM_CFG_CNT_MSB 10
`define ACIM_CFG_BASE_LSB 11
`define ACIM_CFG_BASE_MSB 15
`define ACIM_CTRL_REINIT_BIT 0

// reset values
`define ACIM_CFG_RST 16'h0000
`define ACIM_SERIAL_CB_RST 32'h0000_0000
`define ACIM_CNT_RST 3'h1

// last strap settle count after reset release; settle lasts this count plus one clk_sys cycles
`define ACIM_SETTLE_CYC 2'h3

`endif

// ===== core/acim_pkg.sv
/*
 types of the analog channel image mapper.
 assumes acim_defs.svh is on the include path.
*/
package acim_pkg;
`include "acim_defs.svh"

	typedef enum logic [1:0] {
		ACIM_CPL_GENERIC = 2'h0,
		ACIM_CPL_FIXED_CS = 2'h1,
		ACIM_CPL_MASTER_SEL = 2'h2,
		ACIM_CPL_NO_FB_PARAM = 2'h3
	} acim_coupler_t;

	typedef enum logic [4:0] {
		ACIM_SLOT_UNUSED = 5'h01,
		ACIM_SLOT_CS = 5'h02,
		ACIM_SLOT_RES = 5'h04,
		ACIM_SLOT_DLO = 5'h08,
		ACIM_SLOT_DHI = 5'h10
	} acim_kind_t;

	typedef enum logic [2:0] {
		ACIM_ST_SETTLE = 3'h1,
		ACIM_ST_LOAD = 3'h2,
		ACIM_ST_RUN = 3'h4
	} acim_state_t;

	typedef struct packed {
		acim_kind_t kind;
		logic [1:0] ch;
	} acim_slot_t;

	typedef struct packed {
		logic [4:0] base_byte;
		logic [2:0] chan_count;
		logic [3:0] cs_mask;
		logic word_align;
		logic big_endian;
		acim_coupler_t coupler;
	} acim_cfg_t;

endpackage

// ===== core/acim_sync.sv
/*
 two flip-flop synchroniser for a vector of static pin levels.
 assumes each bit is a slow level; no bus coherence is promised.
*/
`timescale 1ns/100ps
module acim_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [W-1:0] d_async,
	output logic [W-1:0] q_sync
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= d_async;
			sync_ff <= meta_ff;
		end
	end

	assign q_sync = sync_ff;
endmodule // acim_sync

// ===== core/acim_layout.sv
/*
 combinational byte layout of the process image from the active config.
 assumes cfg is stable while the mapper runs; output slot i names the
 content of image byte i relative to the start byte.
*/
`timescale 1ns/100ps
module acim_layout
	import acim_pkg::*;
(
	input acim_cfg_t cfg,
	input wire logic [3:0] cs_eff,
	input wire logic [2:0] count,
	output acim_slot_t slot [`ACIM_IMG_BYTES],
	output logic [`ACIM_PTR_W-1:0] img_len
);
	always_comb begin
		logic [`ACIM_PTR_W-1:0] ptr;
		ptr = '0;
		for (int i = 0; i < `ACIM_IMG_BYTES; i++) begin
			slot[i] = '{kind: ACIM_SLOT_UNUSED, ch: 2'h0};
		end
		for (int c = 0; c < `ACIM_CH_MAX; c++) begin
			if (3'(c) < count) begin
				if (cs_eff[c]) begin
					slot[ptr[3:0]] = '{kind: ACIM_SLOT_CS, ch: 2'(c)}; // [RULE_04]
					ptr = ptr + 5'h01;
					if (cfg.word_align) begin
						slot[ptr[3:0]] = '{kind: ACIM_SLOT_RES, ch: 2'(c)}; // [RULE_09]
						ptr = ptr + 5'h01;
					end
				end
				// little-endian low byte first, big-endian high byte first
				slot[ptr[3:0]] = '{kind: cfg.big_endian ? ACIM_SLOT_DHI : ACIM_SLOT_DLO,
					ch: 2'(c)}; // [RULE_05] [RULE_06] [RULE_07] [RULE_08] [RULE_10]
				ptr = ptr + 5'h01;
				slot[ptr[3:0]] = '{kind: cfg.big_endian ? ACIM_SLOT_DLO : ACIM_SLOT_DHI,
					ch: 2'(c)};
				ptr = ptr + 5'h01; // [RULE_01] [RULE_02]
			end
		end
		img_len = ptr;
	end
endmodule // acim_layout

// ===== core/acim_mapper.sv
/*
 analog channel image mapper: places up to four 16-bit channel results
 and their status bytes into the input process image, picks control
 bytes from the output image, and offers an apb register set.
 assumes channel results and status bytes are on clk_sys; straps are pins.
*/
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/100ps
//
// Behaviour
// [RULE_01] no status byte: two input bytes per channel
// [RULE_02] four channels, no status: eight input bytes
// [RULE_03] fixed-status coupler: status byte low at offset
// [RULE_04] status in input, control in output image
// [RULE_05] little-endian plain: low byte then high byte
// [RULE_06] big-endian plain: high byte then low byte
// [RULE_07] packed little-endian: status, low, high per channel
// [RULE_08] packed big-endian: status, high, low per channel
// [RULE_09] aligned: status word with reserved byte, data word
// [RULE_10] aligned big-endian data word: high byte first
// [RULE_11] aligned mapping starts on a word boundary
// [RULE_12] low byte is result bits 7..0
// [RULE_13] unused bytes are neither read nor written
// [RULE_14] fully evaluated: occupies input and output image
// [RULE_15] parameters over image need mapped status byte
// [RULE_16] master-selected coupler: master names status channels
// [RULE_17] no-fieldbus-param coupler: control via serial path
// [RULE_18] default from straps unless software reconfigures
// [RULE_19] layout fixed from load until next reset; a CTRL reinit while running reloads it here
module acim_mapper
	import acim_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [`ACIM_STRAP_W-1:0] strap_cfg,
	input wire logic [15:0] chan_result [`ACIM_CH_MAX],
	input wire logic [7:0] channel_status_byte [`ACIM_CH_MAX],
	input wire logic [7:0] out_image [`ACIM_IMG_BYTES],
	output logic [7:0] in_image [`ACIM_IMG_BYTES],
	output logic [`ACIM_IMG_BYTES-1:0] in_byte_wr,
	output logic [`ACIM_IMG_BYTES-1:0] out_byte_rd,
	output logic [7:0] channel_control_byte [`ACIM_CH_MAX],
	output logic [`ACIM_PTR_W-1:0] in_img_len,
	output logic [`ACIM_PTR_W-1:0] out_img_len,
	output logic [4:0] image_start_byte,
	output logic map_active,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	// reset release through two flops
	logic rst_meta_ff;
	logic rst_n_ff;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff <= rst_meta_ff;
		end
	end

	// straps are pins: synchronised before use
	logic [`ACIM_STRAP_W-1:0] strap_sync;

	acim_sync #(
		.W(`ACIM_STRAP_W)
	) u_strap_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n_ff),
		.d_async(strap_cfg),
		.q_sync(strap_sync)
	);

	function automatic acim_cfg_t word_to_cfg(input logic [15:0] w);
		acim_cfg_t c;
		c.coupler = acim_coupler_t'(w[`ACIM_CFG_TYPE_MSB:`ACIM_CFG_TYPE_LSB]);
		c.big_endian = w[`ACIM_CFG_BE_BIT];
		c.word_align = w[`ACIM_CFG_ALIGN_BIT];
		c.cs_mask = w[`ACIM_CFG_CS_MSB:`ACIM_CFG_CS_LSB];
		c.chan_count = w[`ACIM_CFG_CNT_MSB:`ACIM_CFG_CNT_LSB];
		c.base_byte = w[`ACIM_CFG_BASE_MSB:`ACIM_CFG_BASE_LSB];
		return c;
	endfunction

	function automatic logic [15:0] cfg_to_word(input acim_cfg_t c);
		logic [15:0] w;
		w = 16'h0000;
		w[`ACIM_CFG_TYPE_MSB:`ACIM_CFG_TYPE_LSB] = c.coupler;
		w[`ACIM_CFG_BE_BIT] = c.big_endian;
		w[`ACIM_CFG_ALIGN_BIT] = c.word_align;
		w[`ACIM_CFG_CS_MSB:`ACIM_CFG_CS_LSB] = c.cs_mask;
		w[`ACIM_CFG_CNT_MSB:`ACIM_CFG_CNT_LSB] = c.chan_count;
		w[`ACIM_CFG_BASE_MSB:`ACIM_CFG_BASE_LSB] = c.base_byte;
		return w;
	endfunction

	// zero channels is treated as one, above four as four
	function automatic logic [2:0] clamp_count(input logic [2:0] n);
		logic [2:0] r;
		r = n;
		if (n == 3'h0) begin
			r = `ACIM_CNT_RST;
		end else if (n > 3'(`ACIM_CH_MAX)) begin
			r = 3'(`ACIM_CH_MAX);
		end
		return r;
	endfunction

	// apb decode
	logic [31:0] nxt_prdata;
	wire apb_setup = psel && !penable;
	wire apb_wr = psel && penable && pwrite;
	wire hit_ctrl = paddr == `ACIM_ADDR_CTRL;
	wire hit_cfg = paddr == `ACIM_ADDR_CFG;
	wire hit_layout = paddr == `ACIM_ADDR_LAYOUT;
	wire hit_scb = paddr == `ACIM_ADDR_SERIAL_CB;
	wire hit_acb = paddr == `ACIM_ADDR_ACTIVE_CB;
	wire hit_any = hit_ctrl || hit_cfg || hit_layout || hit_scb || hit_acb;
	wire reinit_req = apb_wr && hit_ctrl && pwdata[`ACIM_CTRL_REINIT_BIT];

	// registers
	acim_state_t state_ff;
	acim_state_t nxt_state;
	logic [1:0] settle_ff;
	logic from_sw_ff;
	logic [15:0] cfg_shadow_ff;
	logic [31:0] serial_cb_ff;
	acim_cfg_t active_ff;
	logic [31:0] prdata_ff;

	// state machine: settle straps, load layout, then run
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ACIM_ST_SETTLE: begin
				if (settle_ff == `ACIM_SETTLE_CYC) begin
					nxt_state = ACIM_ST_LOAD;
				end
			end
			ACIM_ST_LOAD: begin
				nxt_state = ACIM_ST_RUN;
			end
			ACIM_ST_RUN: begin
				if (reinit_req) begin
					nxt_state = ACIM_ST_LOAD;
				end
			end
			default: begin
				nxt_state = ACIM_ST_SETTLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			state_ff <= ACIM_ST_SETTLE;
			settle_ff <= 2'h0;
		end else begin
			state_ff <= nxt_state;
			if (state_ff == ACIM_ST_SETTLE) begin
				settle_ff <= settle_ff + 2'h1;
			end
		end
	end

	// strap default at load after reset, software copy on reinit
	wire [15:0] load_word = from_sw_ff ? cfg_shadow_ff : strap_sync; // [RULE_18]
	wire loading = state_ff == ACIM_ST_LOAD;

	always_ff @(posedge clk_sys or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			from_sw_ff <= 1'b0;
			active_ff <= acim_cfg_t'(`ACIM_CFG_RST);
		end else begin
			if (reinit_req) begin
				from_sw_ff <= 1'b1;
			end
			if (loading) begin
				active_ff <= word_to_cfg(load_word); // [RULE_19]
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			cfg_shadow_ff <= `ACIM_CFG_RST;
			serial_cb_ff <= `ACIM_SERIAL_CB_RST;
		end else begin
			if (loading && !from_sw_ff) begin
				cfg_shadow_ff <= strap_sync;
			end else if (apb_wr && hit_cfg) begin
				cfg_shadow_ff <= pwdata[15:0];
			end
			if (apb_wr && hit_scb) begin
				serial_cb_ff <= pwdata; // [RULE_17]
			end
		end
	end

	// which channels carry a status/control byte in the image
	logic [3:0] cs_eff;
	logic [2:0] count_eff;
	assign count_eff = clamp_count(active_ff.chan_count);
	always_comb begin
		case (active_ff.coupler)
			ACIM_CPL_FIXED_CS: cs_eff = 4'hf; // [RULE_03]
			ACIM_CPL_MASTER_SEL: cs_eff = active_ff.cs_mask; // [RULE_16]
			ACIM_CPL_NO_FB_PARAM: cs_eff = 4'h0; // [RULE_17]
			default: cs_eff = active_ff.cs_mask;
		endcase
	end

	acim_slot_t slot [`ACIM_IMG_BYTES];
	logic [`ACIM_PTR_W-1:0] img_len;

	acim_layout u_layout (
		.cfg(active_ff),
		.cs_eff(cs_eff),
		.count(count_eff),
		.slot(slot),
		.img_len(img_len)
	);

	// the layout keeps the fixed-status byte at the low byte of the
	// channel offset only when the start byte is even, hence alignment
	assign image_start_byte = active_ff.word_align ?
		((active_ff.base_byte + 5'h01) & 5'h1e) : active_ff.base_byte; // [RULE_11]

	wire running = state_ff == ACIM_ST_RUN;
	assign map_active = running;
	assign in_img_len = running ? img_len : 5'h00;
	assign out_img_len = (running && (cs_eff != 4'h0)) ? img_len : 5'h00; // [RULE_14]

	// input image bytes and their write strobes
	logic [7:0] nxt_in_image [`ACIM_IMG_BYTES];
	logic [`ACIM_IMG_BYTES-1:0] nxt_wr;
	logic [`ACIM_IMG_BYTES-1:0] nxt_rd;
	always_comb begin
		for (int i = 0; i < `ACIM_IMG_BYTES; i++) begin
			nxt_in_image[i] = 8'h00;
			nxt_wr[i] = 1'b0;
			nxt_rd[i] = 1'b0;
			case (slot[i].kind)
				ACIM_SLOT_CS: begin
					nxt_in_image[i] = channel_status_byte[slot[i].ch]; // [RULE_04]
					nxt_wr[i] = running;
					nxt_rd[i] = running;
				end
				ACIM_SLOT_RES: begin
					// reserved byte belongs to the image but carries nothing
					nxt_wr[i] = running; // [RULE_09]
				end
				ACIM_SLOT_DLO: begin
					nxt_in_image[i] = chan_result[slot[i].ch][7:0]; // [RULE_12]
					nxt_wr[i] = running;
				end
				ACIM_SLOT_DHI: begin
					nxt_in_image[i] = chan_result[slot[i].ch][15:8]; // [RULE_12]
					nxt_wr[i] = running;
				end
				default: begin
					nxt_wr[i] = 1'b0; // [RULE_13]
				end
			endcase
		end
	end

	// control bytes: image only where the status byte is mapped
	logic [7:0] img_cb [`ACIM_CH_MAX];
	logic [3:0] img_cb_hit;
	always_comb begin
		for (int c = 0; c < `ACIM_CH_MAX; c++) begin
			img_cb[c] = 8'h00;
			img_cb_hit[c] = 1'b0;
		end
		for (int i = 0; i < `ACIM_IMG_BYTES; i++) begin
			if (slot[i].kind == ACIM_SLOT_CS) begin
				img_cb[slot[i].ch] = out_image[i];
				img_cb_hit[slot[i].ch] = running; // [RULE_15]
			end
		end
	end

	logic [7:0] nxt_cb [`ACIM_CH_MAX];
	always_comb begin
		for (int c = 0; c < `ACIM_CH_MAX; c++) begin
			nxt_cb[c] = img_cb_hit[c] ? img_cb[c] : serial_cb_ff[c*8 +: 8]; // [RULE_17]
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			in_byte_wr <= '0;
			out_byte_rd <= '0;
			for (int i = 0; i < `ACIM_IMG_BYTES; i++) begin
				in_image[i] <= 8'h00;
			end
			for (int c = 0; c < `ACIM_CH_MAX; c++) begin
				channel_control_byte[c] <= 8'h00;
			end
		end else begin
			in_byte_wr <= nxt_wr;
			out_byte_rd <= nxt_rd;
			for (int i = 0; i < `ACIM_IMG_BYTES; i++) begin
				in_image[i] <= nxt_in_image[i];
			end
			for (int c = 0; c < `ACIM_CH_MAX; c++) begin
				channel_control_byte[c] <= nxt_cb[c];
			end
		end
	end

	// apb read data, zero wait: captured in the setup cycle
	// a function result cannot be part-selected, so it gets a name first
	wire [15:0] active_word = cfg_to_word(active_ff);
	wire [31:0] layout_word = {13'h0000, 3'(state_ff), 6'h00, img_len[4:0],
		active_word[4:0]};
	wire [31:0] active_cb_word = {channel_control_byte[3], channel_control_byte[2],
		channel_control_byte[1], channel_control_byte[0]};

	always_comb begin
		nxt_prdata = 32'h0000_0000;
		if (hit_cfg) begin
			nxt_prdata = {16'h0000, cfg_shadow_ff};
		end else if (hit_layout) begin
			nxt_prdata = layout_word;
		end else if (hit_scb) begin
			nxt_prdata = serial_cb_ff;
		end else if (hit_acb) begin
			nxt_prdata = active_cb_word;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			prdata_ff <= 32'h0000_0000;
		end else if (apb_setup) begin
			prdata_ff <= nxt_prdata;
		end
	end

	assign prdata = prdata_ff;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit_any;
endmodule // acim_mapper

// ===== bench/acim_chk.sv
/*
 port checker of acim_mapper.
 assumes a bind onto the mapper and a single clk_sys domain.
*/
`timescale 1ns/100ps
`include "acim_defs.svh"
module acim_chk
	import acim_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [`ACIM_STRAP_W-1:0] strap_cfg,
	input wire logic [15:0] chan_result [`ACIM_CH_MAX],
	input wire logic [7:0] in_image [`ACIM_IMG_BYTES],
	input wire logic [`ACIM_IMG_BYTES-1:0] in_byte_wr,
	input wire logic [`ACIM_PTR_W-1:0] in_img_len,
	input wire logic [`ACIM_PTR_W-1:0] out_img_len,
	input wire logic [4:0] image_start_byte,
	input wire logic map_active
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// straps only; modes after a soft reload are left to the bench
	wire [7:0] mode = strap_cfg[7:0];
	wire [2:0] raw = strap_cfg[10:8];
	wire [2:0] cnt = (raw == 3'h0) ? 3'h1 : (raw > 3'h4) ? 3'h4 : raw;
	sequence s_run;
		map_active ##1 map_active;
	endsequence
	chk_wr_count: assert property (
		s_run |-> $countones(in_byte_wr) == in_img_len) else $error("strobe count off");
	chk_plain_le: assert property (
		s_run ##0 mode == 8'h00 |-> {in_image[1], in_image[0]} == $past(chan_result[0]))
		else $error("little-endian word wrong");
	chk_plain_be: assert property (
		s_run ##0 mode == 8'h04 |-> {in_image[0], in_image[1]} == $past(chan_result[0]))
		else $error("big-endian word wrong");
	chk_fixed_len: assert property (
		map_active && mode[3:0] == 4'h1 |-> in_img_len == 3 * cnt && out_img_len != '0)
		else $error("packed length wrong");
	chk_nofb_len: assert property (
		map_active && mode[1:0] == 2'h3 |-> out_img_len == '0 && in_img_len == 2 * cnt)
		else $error("status mapped without fieldbus access");
	chk_align_even: assert property (
		map_active && strap_cfg[3] |-> !image_start_byte[0]
		&& image_start_byte >= strap_cfg[15:11]) else $error("start not on word");
	chk_layout_hold: assert property (
		s_run |-> $stable(in_img_len) && $stable(image_start_byte))
		else $error("layout moved while running");
	chk_map_start: assert property (
		$rose(resetn) |-> ##[3:12] map_active) else $error("mapping did not start");
endmodule // acim_chk

bind acim_mapper acim_chk u_acim_chk (.clk_sys(clk_sys), .resetn(resetn),
	.strap_cfg(strap_cfg), .chan_result(chan_result), .in_image(in_image),
	.in_byte_wr(in_byte_wr), .in_img_len(in_img_len), .out_img_len(out_img_len),
	.image_start_byte(image_start_byte), .map_active(map_active));

// ===== bench/acim_cpl_model.sv
/*
 coupler side: master configuration and output process image.
 assumes the bench sets the master configuration during reset; t_master also changes it while running.
*/
`timescale 1ns/100ps
`include "acim_defs.svh"
module acim_cpl_model
	import acim_pkg::*;
(
	input wire logic [15:0] master_cfg,
	output logic [`ACIM_STRAP_W-1:0] strap_cfg,
	output logic [7:0] out_image [`ACIM_IMG_BYTES]
);
	// master names coupler type and status channels
	assign strap_cfg = master_cfg;
	// distinct bytes so a wrong control slot shows
	always_comb begin
		for (int i = 0; i < `ACIM_IMG_BYTES; i++) begin
			out_image[i] = 8'h30 + 8'(i);
		end
	end
endmodule // acim_cpl_model

// ===== bench/acim_mapper_tb.sv
/*
 self-checking bench of acim_mapper with the coupler model.
 assumes acim_chk is bound to the mapper; clk_sys at 25 MHz.
*/
`timescale 1ns/100ps
`include "acim_defs.svh"
`define CHK(a, b) begin \
	samples_checked++; \
	if ((a) !== (b)) begin \
		n_fail++; \
		$display("ERROR %0t got %h want %h", $time, a, b); \
	end \
end
module acim_mapper_tb
	import acim_pkg::*;
;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic [15:0] master_cfg = 16'h0000;
	logic [`ACIM_STRAP_W-1:0] strap_cfg;
	logic [15:0] chan_result [`ACIM_CH_MAX];
	logic [7:0] channel_status_byte [`ACIM_CH_MAX];
	logic [7:0] channel_control_byte [`ACIM_CH_MAX];
	logic [7:0] out_image [`ACIM_IMG_BYTES];
	logic [7:0] in_image [`ACIM_IMG_BYTES];
	logic [`ACIM_IMG_BYTES-1:0] in_byte_wr, out_byte_rd;
	logic [`ACIM_PTR_W-1:0] in_img_len, out_img_len;
	logic [4:0] image_start_byte;
	logic map_active, pready, pslverr, err;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = '0, prdata, rd;
	int n_fail = 0, samples_checked = 0, cycles = 0;

	acim_cpl_model u_acim_cpl_model (.master_cfg(master_cfg), .strap_cfg(strap_cfg),
		.out_image(out_image));
	acim_mapper u_acim_mapper (.clk_sys(clk_sys), .resetn(resetn), .strap_cfg(strap_cfg),
		.chan_result(chan_result), .channel_status_byte(channel_status_byte),
		.out_image(out_image), .in_image(in_image), .in_byte_wr(in_byte_wr),
		.out_byte_rd(out_byte_rd), .channel_control_byte(channel_control_byte),
		.in_img_len(in_img_len), .out_img_len(out_img_len),
		.image_start_byte(image_start_byte), .map_active(map_active), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));

	initial begin
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// a run is under 1000 cycles; a hang ends here
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			n_fail++;
			conclude();
		end
	end

	task automatic wait_run();
		int k;
		k = 0;
		while (map_active !== 1'b1 && k < 30) begin
			@(negedge clk_sys);
			k++;
		end
		`CHK(map_active, 1'b1)
		repeat (3) @(posedge clk_sys);
	endtask

	task automatic boot(logic [15:0] c);
		resetn <= 1'b0;
		master_cfg <= c;
		repeat (4) @(posedge clk_sys);
		resetn <= 1'b1;
		wait_run();
	endtask

	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	// bytes beyond the layout must read as zero
	task automatic img(logic [127:0] v, logic [4:0] len, logic o);
		@(negedge clk_sys);
		`CHK(in_img_len, len)
		`CHK(out_img_len != '0, o)
		for (int i = 0; i < `ACIM_IMG_BYTES; i++) begin
			`CHK(in_image[i], v[8*i+:8])
		end
		@(posedge clk_sys);
	endtask

	task automatic t_plain();
		boot(16'h0200);
		img(128'hb2a2b1a1, 5'h04, 1'b0);
		chan_result[0] <= 16'h0ff0;
		repeat (2) @(posedge clk_sys);
		img(128'hb2a20ff0, 5'h04, 1'b0);
		chan_result[0] <= 16'hb1a1;
		apb(1'b0, `ACIM_ADDR_CFG, '0);
		`CHK(rd, 32'h0000_0200)
		apb(1'b0, `ACIM_ADDR_SERIAL_CB, '0);
		`CHK(rd, `ACIM_SERIAL_CB_RST)
		apb(1'b1, 12'h014, 32'hffff_ffff);
		`CHK(err, 1'b1)
		apb(1'b0, 12'h014, '0);
		`CHK({err, rd}, 33'h1_0000_0000)
		boot(16'h0404);
		img(128'ha4b4a3b3a2b2a1b1, 5'h08, 1'b0);
		$display("test plain done");
	endtask

	task automatic t_packed();
		boot(16'h0201);
		img(128'hb2a2c2b1a1c1, 5'h06, 1'b1);
		`CHK(channel_control_byte[1], 8'h33)
		`CHK(out_byte_rd, 16'h0009)
		`CHK(in_byte_wr, 16'h003f)
		boot(16'h0205);
		img(128'ha2b2c2a1b1c1, 5'h06, 1'b1);
		$display("test packed done");
	endtask

	task automatic t_aligned();
		boot(16'h190d);
		img(128'ha1b100c1, 5'h04, 1'b1);
		`CHK(image_start_byte, 5'h04)
		apb(1'b0, `ACIM_ADDR_LAYOUT, '0);
		`CHK(rd, 32'h0004_008d)
		boot(16'h0209);
		img(128'hb2a200c2b1a100c1, 5'h08, 1'b1);
		$display("test aligned done");
	endtask

	task automatic t_nofb();
		boot(16'h02f3);
		img(128'hb2a2b1a1, 5'h04, 1'b0);
		apb(1'b1, `ACIM_ADDR_SERIAL_CB, 32'h4433_2211);
		repeat (2) @(posedge clk_sys);
		`CHK(channel_control_byte[1], 8'h22)
		apb(1'b0, `ACIM_ADDR_ACTIVE_CB, '0);
		`CHK(rd, 32'h4433_2211)
		$display("test nofb done");
	endtask

	task automatic t_master();
		boot(16'h0222);
		img(128'hb2a2c2b1a1, 5'h05, 1'b1);
		`CHK(channel_control_byte[1], 8'h32)
		apb(1'b1, `ACIM_ADDR_CFG, 32'h0000_0100);
		apb(1'b1, `ACIM_ADDR_CTRL, 32'h0000_0001);
		repeat (2) @(posedge clk_sys);
		wait_run();
		img(128'hb1a1, 5'h02, 1'b0);
		master_cfg <= 16'h0422;
		repeat (8) @(posedge clk_sys);
		img(128'hb1a1, 5'h02, 1'b0);
		$display("test master done");
	endtask

	initial begin
		for (int i = 0; i < `ACIM_CH_MAX; i++) begin
			chan_result[i] = {4'hb, 4'(i + 1), 4'ha, 4'(i + 1)};
			channel_status_byte[i] = {4'hc, 4'(i + 1)};
		end
		t_plain();
		t_packed();
		t_aligned();
		t_nofb();
		t_master();
		conclude();
	end
endmodule // acim_mapper_tb
